/* dv/pxa_expander_tb.sv */
// Self-checking bench for the serial port expander
`timescale 1ns/1ps
module pxa_expander_tb;
  import pxa_pkg::*;
  localparam logic [6:0] IN_ADR  = 7'h69;
  localparam logic [6:0] OUT_ADR = 7'h59;
  logic       mclk;
  logic       nrst;
  logic       abort_n;
  logic       scl;
  logic       sda_in;
  logic       sda_out;
  logic       sda_oe;
  pxa_byte_t  in_port;
  logic       addr_sel_low;
  logic       addr_sel_high;
  pxa_byte_t  out_port;
  pxa_byte_t  pullup_en;
  logic       alert_n;
  logic       standby;
  pxa_byte_t  b1;
  pxa_byte_t  b2;
  logic       ak;
  logic       g;
  int         mismatches;
  int         comparisons;

  pxa_expander u_pxa_expander (
    .mclk,
    .nrst,
    .abort_n,
    .scl,
    .sda_in,
    .sda_out,
    .sda_oe,
    .in_port,
    .addr_sel_low,
    .addr_sel_high,
    .out_port,
    .pullup_en,
    .alert_n,
    .standby
  );

  pxa_master_model u_pxa_master_model (
    .mclk,
    .sda_oe,
    .sda_out,
    .scl,
    .sda_in
  );

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk_byte(input string n, input pxa_byte_t e,
                          input pxa_byte_t s);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic s);
    chk_byte(n, {7'h00, e}, {7'h00, s});
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Returns high when either byte went unacknowledged
  task automatic wr(input logic [6:0] a, input pxa_byte_t d,
                    output logic k);
    pxa_byte_t q;
    logic      h;
    u_pxa_master_model.start();
    u_pxa_master_model.xbyte({a, 1'b0}, 1'b1, q, h);
    u_pxa_master_model.xbyte(d, 1'b1, q, k);
    u_pxa_master_model.stop();
    k = k | h;
  endtask

  task automatic rd(input logic [6:0] a, output pxa_byte_t r1,
                    output pxa_byte_t r2);
    logic h;
    u_pxa_master_model.start();
    u_pxa_master_model.xbyte({a, 1'b1}, 1'b1, r1, h);
    u_pxa_master_model.xbyte(8'hFF, 1'b0, r1, h);
    u_pxa_master_model.xbyte(8'hFF, 1'b1, r2, h);
    u_pxa_master_model.stop();
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    end_of_test();
  end

  initial
  begin
    nrst          = 1'b0;
    abort_n       = 1'b1;
    in_port       = 8'h5A;
    addr_sel_low  = 1'b1;
    addr_sel_high = 1'b0;
    mismatches    = 0;
    comparisons   = 0;
    cyc(4);
    nrst <= 1'b1;
    cyc(4);
    chk_byte("out_port", 8'h0F, out_port);
    chk_byte("pullup_en", 8'h0F, pullup_en);
    chk_bit("alert_n", 1'b1, alert_n);
    chk_bit("standby", 1'b1, standby);
    rd(IN_ADR, b1, b2);
    chk_byte("inputs", 8'h5A, b1);
    chk_byte("flags", 8'h00, b2);
    done("powerup");
    // Pulse shorter than a read, must still latch
    in_port <= 8'h52;
    cyc(5);
    in_port <= 8'h5A;
    cyc(8);
    chk_bit("alert_n", 1'b0, alert_n);
    u_pxa_master_model.hi_wait = 7;
    rd(IN_ADR, b1, b2);
    u_pxa_master_model.hi_wait = 4;
    chk_byte("flags", 8'h08, b2);
    chk_bit("alert_n", 1'b1, alert_n);
    done("transient");
    wr(IN_ADR, 8'h01, ak);
    chk_bit("ack", 1'b0, ak);
    in_port <= 8'h4A;
    cyc(8);
    chk_bit("alert_n", 1'b1, alert_n);
    in_port <= 8'h4B;
    cyc(8);
    chk_bit("alert_n", 1'b0, alert_n);
    abort_n <= 1'b0;
    cyc(4);
    abort_n <= 1'b1;
    cyc(2);
    chk_bit("alert_n", 1'b0, alert_n);
    done("mask");
    u_pxa_master_model.start();
    u_pxa_master_model.xbyte({OUT_ADR, 1'b0}, 1'b1, b1, g);
    abort_n <= 1'b0;
    u_pxa_master_model.xbyte(8'h3C, 1'b1, b1, ak);
    abort_n <= 1'b1;
    u_pxa_master_model.stop();
    chk_bit("ack", 1'b1, ak);
    chk_byte("out_port", 8'h0F, out_port);
    wr(OUT_ADR, 8'hA5, ak);
    chk_byte("out_port", 8'hA5, out_port);
    rd(OUT_ADR, b1, b2);
    chk_byte("out_read", 8'hA5, b1);
    done("abort");
    u_pxa_master_model.start();
    chk_bit("standby", 1'b0, standby);
    u_pxa_master_model.xbyte({7'h4C, 1'b0}, 1'b1, b1, g);
    u_pxa_master_model.stop();
    cyc(4);
    chk_bit("ack", 1'b1, g);
    chk_bit("standby", 1'b1, standby);
    done("foreign");
    nrst <= 1'b0;
    cyc(4);
    chk_byte("out_port", 8'hFF, out_port);
    nrst <= 1'b1;
    cyc(4);
    chk_byte("out_port", 8'h0F, out_port);
    in_port <= 8'h5B;
    cyc(8);
    chk_bit("alert_n", 1'b0, alert_n);
    rd(IN_ADR, b1, b2);
    chk_byte("inputs", 8'h5B, b1);
    chk_byte("flags", 8'h10, b2);
    done("rereset");
    end_of_test();
  end
endmodule

/* dv/pxa_master_model.sv */
// Two-wire bus master model facing the expander
`timescale 1ns/1ps
module pxa_master_model (
  input  wire logic mclk,
  input  wire logic sda_oe,
  input  wire logic sda_out,
  output logic      scl,
  output logic      sda_in
);
  logic m_sda;
  int   hi_wait = 4;

  // Pulled-up data line, so a released line reads high
  assign sda_in = m_sda & (sda_oe ? sda_out : 1'b1);

  initial
  begin
    scl   = 1'b1;
    m_sda = 1'b1;
  end

  // Clock stands high between frames
  task automatic start();
    m_sda <= 1'b1;
    repeat (2) @(posedge mclk);
    scl <= 1'b1;
    repeat (hi_wait) @(posedge mclk);
    m_sda <= 1'b0;
    repeat (hi_wait) @(posedge mclk);
    scl <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic stop();
    m_sda <= 1'b0;
    repeat (2) @(posedge mclk);
    scl <= 1'b1;
    repeat (hi_wait) @(posedge mclk);
    m_sda <= 1'b1;
    repeat (hi_wait) @(posedge mclk);
  endtask

  // Data moves only while the clock is low
  task automatic bit_io(input logic d, output logic q);
    m_sda <= d;
    repeat (2) @(posedge mclk);
    scl <= 1'b1;
    repeat (hi_wait) @(posedge mclk);
    q = sda_in;
    scl <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic xbyte(input logic [7:0] d, input logic ack,
                       output logic [7:0] q, output logic got);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ack, got);
  endtask
endmodule

/* rtl/pxa_expander.sv */
// Serial port expander: eight inputs with alerts, eight outputs
`timescale 1ns/1ps
module pxa_expander
  import pxa_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               nrst,
  input  wire logic               abort_n,
  input  wire logic               scl,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe,
  input  wire pxa_pkg::pxa_byte_t in_port,
  input  wire logic               addr_sel_low,
  input  wire logic               addr_sel_high,
  output pxa_pkg::pxa_byte_t      out_port,
  output pxa_pkg::pxa_byte_t      pullup_en,
  output logic                    alert_n,
  output logic                    standby
);
  import pxa_pkg::*;

  pxa_ser_t        s;
  pxa_ser_t        s_nxt;
  pxa_core_t       c;
  pxa_core_t       c_nxt;
  pxa_ev_t         ev;
  logic            s_scl;
  logic            s_sda;
  logic            s_a0;
  logic            s_a2;
  pxa_byte_t       s_in;
  logic            scl_rise;
  logic            scl_fall;
  logic            start_c;
  logic            stop_c;
  logic [3:0]      adr_lo4;
  logic            hit_out;
  logic            hit_in;
  pxa_byte_t       diff;

  pxa_sync #(.W(SYNC_W)) u_sync (
    .mclk (mclk),
    .nrst (nrst),
    .d    ({scl, sda_in, addr_sel_low, addr_sel_high, in_port}),
    .q    ({s_scl, s_sda, s_a0, s_a2, s_in})
  );

  assign scl_rise = s_scl & ~c.scl_q;
  assign scl_fall = ~s_scl & c.scl_q;
  assign start_c  = c.scl_q & s_scl & c.sda_q & ~s_sda;
  assign stop_c   = c.scl_q & s_scl & ~c.sda_q & s_sda;
  assign diff     = s_in ^ c.snap;

  assign adr_lo4 = {c.code_hi ^ PIN_FLIP, c.code_lo};
  assign hit_out = s.sh[7:1] == {ADR_OUT_HI, adr_lo4};
  assign hit_in  = s.sh[7:1] == {ADR_IN_HI, adr_lo4};

  // Tracker bits: high seen, low seen, equals scl, equals sda
  function automatic logic [3:0] trk_upd(input logic [3:0] t,
                                          input logic p);
    trk_upd = {t[3] | p, t[2] | ~p, t[1] & (p == s_scl),
               t[0] & (p == s_sda)};
    trk_upd = {trk_upd[1:0], trk_upd[3:2]};
  endfunction

  function automatic pxa_con_t classify(input logic [3:0] t);
    // Layout after update: {eq_scl, eq_sda, hi_seen, lo_seen}
    if (!t[0])
      classify = CON_VP;
    else if (!t[1])
      classify = CON_GND;
    else if (t[3])
      classify = CON_SCL;
    else
      classify = CON_SDA;
  endfunction

  // Serial engine
  always_comb
  begin
    s_nxt   = s;
    ev      = '0;
    ev.data = s.sh;
    if (start_c)
    begin
      s_nxt.st     = ST_ADDR;
      s_nxt.cnt    = '0;
      s_nxt.sda_oe = 1'b0;
    end
    else if (stop_c)
    begin
      s_nxt.st     = ST_IDLE;
      s_nxt.sda_oe = 1'b0;
    end
    else
    begin
      case (s.st)
        ST_IDLE:
          s_nxt.sda_oe = 1'b0;
        ST_ADDR, ST_WDAT:
        begin
          if (scl_rise)
          begin
            s_nxt.sh  = {s.sh[6:0], s_sda};
            s_nxt.cnt = s.cnt + 4'h1;
          end
          else if (scl_fall && s.cnt == BIT_LAST_W)
          begin
            s_nxt.cnt = '0;
            if (s.st == ST_WDAT)
            begin
              s_nxt.st     = ST_WACK;
              s_nxt.sda_oe = 1'b1;
              ev.wr_out    = ~s.tgt_in;
              ev.wr_mask   = s.tgt_in;
            end
            else if (hit_out || hit_in)
            begin
              s_nxt.st     = ST_AACK;
              s_nxt.sda_oe = 1'b1;
              s_nxt.rnw    = s.sh[0];
              s_nxt.tgt_in = hit_in;
            end
            else
              s_nxt.st = ST_IDLE;
          end
        end
        ST_AACK, ST_WACK:
        begin
          if (scl_rise)
          begin
            ev.snap          = 1'b1;
            s_nxt.prev_flags = c.flags;
            s_nxt.sh         = s.tgt_in ? s_in : c.outv;
            s_nxt.rdsel      = 1'b1;
          end
          else if (scl_fall)
          begin
            s_nxt.cnt = '0;
            if (s.rnw)
            begin
              s_nxt.st     = ST_RDAT;
              s_nxt.sda_oe = ~s.sh[7];
            end
            else
            begin
              s_nxt.st     = ST_WDAT;
              s_nxt.sda_oe = 1'b0;
            end
          end
        end
        ST_RDAT:
        begin
          if (scl_fall)
          begin
            if (s.cnt == BIT_LAST_R)
            begin
              s_nxt.st     = ST_MACK;
              s_nxt.sda_oe = 1'b0;
            end
            else
            begin
              s_nxt.sh     = {s.sh[6:0], 1'b0};
              s_nxt.sda_oe = ~s.sh[6];
              s_nxt.cnt    = s.cnt + 4'h1;
            end
          end
        end
        ST_MACK:
        begin
          if (scl_rise)
          begin
            if (s_sda)
              s_nxt.st = ST_IDLE;
            else if (s.tgt_in && s.rdsel)
              s_nxt.sh = s.prev_flags;
            else
              s_nxt.sh = s.tgt_in ? s_in : c.outv;
            s_nxt.rdsel = ~s.rdsel;
          end
          else if (scl_fall)
          begin
            s_nxt.st     = ST_RDAT;
            s_nxt.cnt    = '0;
            s_nxt.sda_oe = ~s.sh[7];
          end
        end
        default:
          s_nxt.st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst or negedge abort_n)
  begin
    if (!nrst || !abort_n)
      s <= '0;
    else
      s <= s_nxt;
  end

  // Port, detection and address logic
  always_comb
  begin
    c_nxt       = c;
    c_nxt.scl_q = s_scl;
    c_nxt.sda_q = s_sda;
    if (!c.loaded)
    begin
      // default outputs from pins caught after release
      c_nxt.loaded  = 1'b1;
      c_nxt.code_lo = s_a0 ? CON_VP : CON_GND;
      c_nxt.code_hi = s_a2 ? CON_VP : CON_GND;
      c_nxt.outv    = {{4{s_a2}}, {4{s_a0}}};
    end
    // clear at acknowledge, else latch any difference
    if (ev.snap || !c.loaded)
    begin
      c_nxt.snap  = s_in;
      c_nxt.flags = '0;
    end
    else
      c_nxt.flags = c.flags | diff;
    if (ev.wr_out)
      c_nxt.outv = ev.data;
    if (ev.wr_mask)
      c_nxt.mask = ev.data;
    // Pin connection re-learned on every transmission
    if (start_c)
    begin
      c_nxt.busy   = 1'b1;
      c_nxt.trk_lo = TRK_RST;
      c_nxt.trk_hi = TRK_RST;
    end
    else if (stop_c && c.busy)
    begin
      c_nxt.busy    = 1'b0;
      c_nxt.code_lo = classify(trk_upd(c.trk_lo, s_a0));
      c_nxt.code_hi = classify(trk_upd(c.trk_hi, s_a2));
    end
    else if (c.busy)
    begin
      c_nxt.trk_lo = {trk_upd(c.trk_lo, s_a0)};
      c_nxt.trk_hi = {trk_upd(c.trk_hi, s_a2)};
      c_nxt.trk_lo = {c_nxt.trk_lo[1:0], c_nxt.trk_lo[3:2]};
      c_nxt.trk_hi = {c_nxt.trk_hi[1:0], c_nxt.trk_hi[3:2]};
    end
    // pullups per nibble, off only for a low pin
    c_nxt.pu = {{4{c_nxt.code_hi != CON_GND}},
                {4{c_nxt.code_lo != CON_GND}}};
    c_nxt.alert_n = ~|(c_nxt.flags & c_nxt.mask);
    // standby whenever the bus is quiet
    c_nxt.standby = ~c_nxt.busy && (s_nxt.st == ST_IDLE);
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      c         <= '0;
      c.scl_q   <= 1'b1;
      c.sda_q   <= 1'b1;
      c.mask    <= MASK_RST;
      c.outv    <= OUT_RST;
      c.alert_n <= 1'b1;
      c.code_lo <= CON_VP;
      c.code_hi <= CON_VP;
    end
    else
      c <= c_nxt;
  end

  assign sda_out   = s.sda_o;
  assign sda_oe    = s.sda_oe;
  assign out_port  = c.outv;
  assign pullup_en = c.pu;
  assign alert_n   = c.alert_n;
  assign standby   = c.standby;

  a_ack_clears: assert property (
    @(posedge mclk) disable iff (!nrst)
    ev.snap |=> alert_n && c.flags == '0)
    else $error("access did not clear flags and alert");

  a_flag_latch: assert property (
    @(posedge mclk) disable iff (!nrst)
    c.loaded && !ev.snap && diff != '0
      |=> (c.flags & $past(diff)) == $past(diff))
    else $error("input change not latched");

  a_mask_gate: assert property (
    @(posedge mclk) disable iff (!nrst)
    c.loaded && c.mask == '0 |-> alert_n)
    else $error("alert raised by masked input");

  a_mask_reset: assert property (
    @(posedge mclk) disable iff (!nrst)
    !c.loaded |-> c.mask == MASK_RST && alert_n && c.flags == '0)
    else $error("wrong power-up mask or flags");

  a_out_default: assert property (
    @(posedge mclk) disable iff (!nrst)
    !c.loaded |=> out_port == {{4{$past(s_a2)}}, {4{$past(s_a0)}}})
    else $error("wrong power-up output levels");

  a_snap_take: assert property (
    @(posedge mclk) disable iff (!nrst)
    ev.snap |=> c.snap == $past(s_in))
    else $error("snapshot not taken at acknowledge");

  a_stop_idle: assert property (
    @(posedge mclk) disable iff (!nrst || !abort_n)
    stop_c |=> s.st == ST_IDLE && !sda_oe)
    else $error("interface not idle after stop");

  a_abort_keep: assert property (
    @(posedge mclk) disable iff (!nrst)
    !abort_n && !ev.snap |=> (c.flags & $past(c.flags)) == $past(c.flags))
    else $error("abort disturbed the flags");

  a_addr_miss: assert property (
    @(posedge mclk) disable iff (!nrst || !abort_n)
    s.st == ST_ADDR && scl_fall && s.cnt == BIT_LAST_W
      && !hit_out && !hit_in |=> s.st == ST_IDLE && !sda_oe)
    else $error("acknowledged a foreign address");

  a_quiet_standby: assert property (
    @(posedge mclk) disable iff (!nrst)
    ##1 (s.st == ST_IDLE && !c.busy) [*2] |-> standby)
    else $error("idle bus without standby");

  c_read_in:  cover property (@(posedge mclk) disable iff (!nrst)
    s.st == ST_MACK && s.tgt_in && !s.rdsel);
  c_write_out: cover property (@(posedge mclk) disable iff (!nrst)
    ev.wr_out);
  c_write_mask: cover property (@(posedge mclk) disable iff (!nrst)
    ev.wr_mask);
  c_alert: cover property (@(posedge mclk) disable iff (!nrst)
    $fell(alert_n));
endmodule

/* rtl/pxa_pkg.sv */
// Shared types and constants for the serial port expander
package pxa_pkg;

  localparam int        NPORT      = 8;
  localparam logic [2:0] ADR_OUT_HI = 3'h5;
  localparam logic [2:0] ADR_IN_HI  = 3'h6;
  localparam logic [7:0] MASK_RST   = 8'hFF;
  localparam logic [7:0] OUT_RST    = 8'hFF;
  localparam logic [3:0] BIT_LAST_W = 4'h8;
  localparam logic [3:0] BIT_LAST_R = 4'h7;
  localparam logic [3:0] TRK_RST    = 4'h3;
  localparam logic [1:0] PIN_FLIP   = 2'h2;
  localparam int        SYNC_W     = 12;

  typedef logic [7:0] pxa_byte_t;

  // Four-level address pin connection
  typedef enum logic [1:0] {
    CON_GND = 2'b00,
    CON_VP  = 2'b01,
    CON_SCL = 2'b10,
    CON_SDA = 2'b11
  } pxa_con_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_WDAT = 3'b011,
    ST_WACK = 3'b100,
    ST_RDAT = 3'b101,
    ST_MACK = 3'b110
  } pxa_st_t;

  // Serial engine state
  typedef struct packed {
    pxa_st_t   st;
    logic [3:0] cnt;
    pxa_byte_t sh;
    pxa_byte_t prev_flags;
    logic      rdsel;
    logic      rnw;
    logic      tgt_in;
    logic      sda_oe;
    logic      sda_o;
  } pxa_ser_t;

  // Port and detection state
  typedef struct packed {
    logic      scl_q;
    logic      sda_q;
    logic      loaded;
    logic      busy;
    pxa_byte_t snap;
    pxa_byte_t flags;
    pxa_byte_t mask;
    pxa_byte_t outv;
    pxa_byte_t pu;
    pxa_con_t  code_lo;
    pxa_con_t  code_hi;
    logic [3:0] trk_lo;
    logic [3:0] trk_hi;
    logic      alert_n;
    logic      standby;
  } pxa_core_t;

  // One-cycle events from serial engine to port logic
  typedef struct packed {
    logic      snap;
    logic      wr_out;
    logic      wr_mask;
    pxa_byte_t data;
  } pxa_ev_t;

endpackage

/* rtl/pxa_sync.sv */
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module pxa_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second
  // No reset: pins stay sampled during reset, valid at release
  always_ff @(posedge mclk)
  begin
    meta_r <= d;
    q      <= meta_r;
  end
endmodule
